//--- verif/ata_command_block_executor_tb.sv
`default_nettype none
module ata_command_block_executor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, arst_n, blk_valid, reg_wr, reg_rd, tf_ack, dp_done, dp_dev_err, dp_phase_err, load;
  logic blk_ready, tf_req, tf_write, tf_ctrl_blk, dp_start, dp_udma, dp_identify, dp_halt, rb_valid, busy;
  logic [7:0] blk_byte, reg_addr, tf_wdata, tf_rdata, rb_byte, sig;
  logic [31:0] reg_wdata, reg_rdata, r;
  logic [2:0] tf_addr, ack_dly;
  logic [3:0] busy_polls;
  logic [1:0] err_mode;
  logic [12:0] obs[$], expq[$];
  logic [7:0] rbq[$];
  logic [31:0] seed = 32'h242825bf;
  int err_count, comparisons, n_start, n_halt;
  int mirror [8];
  logic udma_seen, ident_seen, pend, lun;
  // Host never sets ultra DMA for an incapable drive nor continue flags on readback
  logic [7:0] acts [10] = '{8'h01, 8'h07, 8'h00, 8'h06, 8'h62, 8'ha4, 8'h00, 8'h10, 8'h00, 8'h08};
  logic [1:0] errs [10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  ata_command_block_executor ata_command_block_executor_inst (.mclk, .arst_n, .blk_valid, .blk_byte,
    .blk_ready, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tf_req, .tf_write, .tf_ctrl_blk,
    .tf_addr, .tf_wdata, .tf_ack, .tf_rdata, .dp_start, .dp_udma, .dp_identify, .dp_done, .dp_dev_err,
    .dp_phase_err, .dp_halt, .rb_valid, .rb_byte, .busy);
  ata_drive_model ata_drive_model_inst (.mclk, .arst_n, .tf_req, .tf_write, .tf_ctrl_blk, .tf_addr,
    .tf_wdata, .tf_ack, .tf_rdata, .dp_start, .dp_halt, .dp_done, .dp_dev_err, .dp_phase_err, .ack_dly,
    .busy_polls, .load, .err_mode);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands one cycle, picked up at the edge that closes it
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    d = reg_rdata;
  endtask
  always @(posedge mclk) begin
    if (tf_req && tf_ack) obs.push_back({tf_write, tf_ctrl_blk, tf_addr, tf_write ? tf_wdata : 8'h00});
    if (rb_valid) rbq.push_back(rb_byte);
    if (dp_halt) n_halt++;
    if (dp_start) n_start++;
    if (pend) udma_seen = dp_udma;
    if (pend) ident_seen = dp_identify;
    pend = dp_start;
  end
  task automatic run(input logic [7:0] a, input logic [7:0] m, input logic [1:0] e, input logic bad);
    logic [7:0] b [16];
    logic [63:0] erb;
    logic [7:0] sel;
    logic h;
    int polls;
    for (int k = 0; k < 16; k++) b[k] = (k > 4 && k < 13) ? 8'(rnd()) : 8'h00;
    b[0] = bad ? ~sig : sig;
    b[1] = 8'h24;
    b[2] = a;
    b[3] = m;
    b[4] = 8'h01;
    polls = a[2] ? 0 : int'(rnd() % 4);
    sel = {b[11][7:5], a[5] ? b[11][4] : lun, b[11][3:0]};
    h = !bad && !a[0] && ((e == 2'h1 && !a[4]) || (e == 2'h2 && !a[3]));
    expq.delete();
    for (int k = 0; k <= polls && !bad && !a[2]; k++) expq.push_back({2'b01, 3'h6, 8'h00});
    if (!bad && !a[0] && !a[1]) expq.push_back({2'b10, 3'h6, sel});
    for (int k = 0; k < 8; k++) begin
      if (!bad && m[k]) expq.push_back({!a[0], k == 0, k == 0 ? 3'h6 : 3'(k), a[0] ? 8'h00 : k == 6 ? sel : b[5 + k]});
      erb[8 * k +: 8] = !m[k] ? 8'h00 : (k == 0 || k == 7) ? 8'h50 : 8'(mirror[k]);
      if (!bad && !a[0] && m[k] && k > 0 && k < 6) mirror[k] = b[5 + k];
    end
    if (!bad && !a[0]) mirror[6] = sel;
    if (!bad && !a[0] && a[1]) expq.push_back({2'b10, 3'h6, sel});
    busy_polls <= 4'(polls);
    ack_dly <= 3'(rnd() % 5);
    err_mode <= e;
    load <= 1'b1;
    @(posedge mclk);
    load <= 1'b0;
    obs.delete();
    rbq.delete();
    n_start = 0;
    n_halt = 0;
    for (int k = 0; k < 100 && !blk_ready; k++) @(posedge mclk);
    for (int k = 0; k < 16; k++) begin
      blk_valid <= 1'b1;
      blk_byte <= b[k];
      @(posedge mclk);
    end
    blk_valid <= 1'b0;
    repeat (3) @(posedge mclk);
    for (int k = 0; k < 2000 && busy; k++) @(posedge mclk);
    chk(busy, 1'b0);
    repeat (2) @(posedge mclk);
    chk(obs.size(), expq.size());
    for (int k = 0; k < expq.size() && k < obs.size(); k++) chk(obs[k], expq[k]);
    chk(rbq.size(), (!bad && a[0]) ? 8 : 0);
    for (int k = 0; k < 8 && k < rbq.size(); k++) chk(rbq[k], erb[8 * k +: 8]);
    if (!bad && a[0]) begin
      rd(8'h0c, r);
      chk(r, erb[31:0]);
      rd(8'h10, r);
      chk(r, erb[63:32]);
    end
    chk(n_start, !bad && !a[0]);
    if (!bad && !a[0]) chk(udma_seen, a[6]);
    if (!bad && !a[0]) chk(ident_seen, a[7]);
    chk(n_halt, h);
    rd(8'h08, r);
    chk(r[2:0], {h, bad, 1'b0});
    if (!bad) chk(r[15:8], a);
    wr(8'h08, 32'h6);
    $display("block action %h mask %h error %0d finished", a, m, e);
  endtask
  initial begin
    {blk_valid, reg_wr, reg_rd, load, lun} = 5'h00;
    {blk_byte, reg_addr, reg_wdata, ack_dly, busy_polls, err_mode} = '0;
    sig = 8'h5a;
    for (int k = 0; k < 8; k++) mirror[k] = 8'h30 + k;
    arst_n = 1'b0;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(8'h00, r);
    chk(r, 32'h5a);
    rd(8'h04, r);
    chk(r, 32'h0);
    rd(8'h08, r);
    chk(r, 32'h0);
    wr(8'h14, 32'hffffffff);
    rd(8'h14, r);
    chk(r, 32'h0);
    run(8'h00, 8'hff, 2'h0, 1'b0);
    sig = 8'(rnd());
    wr(8'h00, {24'h0, sig});
    lun = 1'b1;
    @(posedge mclk);
    wr(8'h04, 32'h1);
    rd(8'h00, r);
    chk(r, {24'h0, sig});
    $display("register test finished");
    run(8'h00, 8'hff, 2'h0, 1'b1);
    for (int t = 0; t < 10; t++) run(acts[t], t == 0 ? 8'hff : 8'(rnd()), errs[t], 1'b0);
    conclude();
  end
  initial begin
    repeat (40000) @(posedge mclk);
    err_count++;
    conclude();
  end
endmodule
`default_nettype wire

//--- verif/ata_drive_model.sv
`default_nettype none
module ata_drive_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic tf_req,
  input wire logic tf_write,
  input wire logic tf_ctrl_blk,
  input wire logic [2:0] tf_addr,
  input wire logic [7:0] tf_wdata,
  output logic tf_ack,
  output logic [7:0] tf_rdata,
  input wire logic dp_start,
  input wire logic dp_halt,
  output logic dp_done,
  output logic dp_dev_err,
  output logic dp_phase_err,
  input wire logic [2:0] ack_dly,
  input wire logic [3:0] busy_polls,
  input wire logic load,
  input wire logic [1:0] err_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] regs [8];
  logic [3:0] busy_left;
  logic [2:0] wait_cnt;
  logic [3:0] dp_cnt;
  logic in_phase;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tf_ack <= 1'b0;
      tf_rdata <= 8'h00;
      busy_left <= 4'h0;
      wait_cnt <= 3'h0;
      for (int k = 0; k < 8; k++) regs[k] <= 8'h30 + 8'(k);
      dp_cnt <= 4'h0;
      in_phase <= 1'b0;
      dp_done <= 1'b0;
      dp_dev_err <= 1'b0;
      dp_phase_err <= 1'b0;
    end else begin
      tf_ack <= 1'b0;
      // Idle bus toggles so stale data never looks valid
      tf_rdata <= ~tf_rdata;
      if (load) busy_left <= busy_polls;
      if (tf_req && !tf_ack) begin
        wait_cnt <= wait_cnt + 3'h1;
        if (wait_cnt >= ack_dly) begin
          wait_cnt <= 3'h0;
          tf_ack <= 1'b1;
          if (tf_ctrl_blk) begin
            tf_rdata <= (busy_left != 4'h0) ? 8'h80 : 8'h50;
            if (!tf_write && busy_left != 4'h0) busy_left <= busy_left - 4'h1;
          end else if (tf_write) begin
            regs[tf_addr] <= tf_wdata;
          end else begin
            tf_rdata <= (tf_addr == 3'h0 || tf_addr == 3'h7) ? 8'h50 : regs[tf_addr];
          end
        end
      end
      dp_done <= 1'b0;
      if (dp_start) begin
        in_phase <= 1'b1;
        dp_cnt <= 4'h0;
      end else if (in_phase) begin
        dp_cnt <= dp_cnt + 4'h1;
        if (dp_halt || dp_cnt == 4'h6) in_phase <= 1'b0;
        dp_done <= !dp_halt && dp_cnt == 4'h6;
      end
      dp_dev_err <= err_mode == 2'h1 && (dp_start || in_phase);
      dp_phase_err <= err_mode == 2'h2 && (dp_start || in_phase);
    end
  end
endmodule
`default_nettype wire

//--- verilog/ata_block_pkg.sv
// What this block does
// - Identify flag marks the data phase as drive identify data.
// - Ultra DMA flag selects ultra DMA data moves, otherwise PIO only.
// - Drive-select bit comes from startup unit value or block byte 0x0b bit 4.
// - Drive error halts data accesses unless the device-fault continue flag is set.
// - Phase error halts data accesses unless the phase-fault continue flag is set.
// - Poll alternate status until busy clears, unless skip-poll flag is set.
// - Drive selection precedes register writes, or follows them when late flag set.
// - Readback flag: only read masked registers, zero others, no command.
// - Readback bytes 0..7 ordered alt status through command/status.
// - Apart from status polls and drive selection, only registers whose mask bit is set are accessed.
// - Readback is always eight bytes, unmasked bytes zero.
// - Accesses run one at a time, mask bit 0 up to bit 7.
// - Mask bits 0..4: control/alt status, features, count, number, cylinder low.
// - Block accepted only when byte 0 matches the configured signature.
// - Mask bits 5..7: cylinder high, device/head, command/status last.
// - Write values come from block bytes 0x05..0x0c for masked registers.
`default_nettype none
package ata_block_pkg;
  localparam logic [3:0] blk_last = 4'hf;
  localparam logic [3:0] byte_sig = 4'h0;
  localparam logic [3:0] byte_sub = 4'h1;
  localparam logic [3:0] byte_action = 4'h2;
  localparam logic [3:0] byte_mask = 4'h3;
  localparam logic [3:0] byte_wr_base = 4'h5;
  localparam logic [3:0] byte_devhead = 4'hb;
  localparam logic [7:0] subcmd_value = 8'h24;
  localparam int flag_identify = 7;
  localparam int flag_udma = 6;
  localparam int flag_dev_src = 5;
  localparam int flag_dev_cont = 4;
  localparam int flag_phase_cont = 3;
  localparam int flag_skip_poll = 2;
  localparam int flag_late_sel = 1;
  localparam int flag_readback = 0;
  localparam int drive_sel_pos = 4;
  localparam int busy_pos = 7;
  localparam logic [2:0] alt_status_addr = 3'h6;
  localparam logic [2:0] devhead_addr = 3'h6;
  localparam logic [2:0] devhead_bit = 3'h6;
  localparam logic [2:0] rb_last = 3'h7;
  localparam logic [7:0] off_sig = 8'h00;
  localparam logic [7:0] off_ctrl = 8'h04;
  localparam logic [7:0] off_status = 8'h08;
  localparam logic [7:0] off_rb_lo = 8'h0c;
  localparam logic [7:0] off_rb_hi = 8'h10;
  // Arbitrary default, software loads the real signature
  localparam logic [7:0] sig_reset = 8'h5a;
  localparam logic lun_reset = 1'b0;
  typedef enum logic [8:0] {
    st_idle = 9'h001,
    st_check = 9'h002,
    st_poll = 9'h004,
    st_sel = 9'h008,
    st_scan = 9'h010,
    st_fetch = 9'h020,
    st_acc = 9'h040,
    st_data = 9'h080,
    st_rbout = 9'h100
  } exec_state_e;
endpackage
`default_nettype wire

//--- verilog/ata_command_block_executor.sv
`default_nettype none
module ata_command_block_executor (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic blk_valid,
  input wire logic [7:0] blk_byte,
  output logic blk_ready,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic tf_req,
  output logic tf_write,
  output logic tf_ctrl_blk,
  output logic [2:0] tf_addr,
  output logic [7:0] tf_wdata,
  input wire logic tf_ack,
  input wire logic [7:0] tf_rdata,
  output logic dp_start,
  output logic dp_udma,
  output logic dp_identify,
  input wire logic dp_done,
  input wire logic dp_dev_err,
  input wire logic dp_phase_err,
  output logic dp_halt,
  output logic rb_valid,
  output logic [7:0] rb_byte,
  output logic busy
);
  ata_block_pkg::exec_state_e state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sig_ff, nxt_sig, sub_ff, nxt_sub, action_ff, nxt_action;
  logic [7:0] mask_ff, nxt_mask, devhead_ff, nxt_devhead;
  logic [3:0] idx_ff, nxt_idx;
  logic [2:0] acc_ff, nxt_acc, rbcnt_ff, nxt_rbcnt;
  logic [63:0] rb_ff, nxt_rb;
  logic tf_req_ff, nxt_tf_req, tf_write_ff, nxt_tf_write, tf_ctrl_ff, nxt_tf_ctrl;
  logic [2:0] tf_addr_ff, nxt_tf_addr;
  logic [7:0] tf_wdata_ff, nxt_tf_wdata;
  logic dp_start_ff, nxt_dp_start, dp_udma_ff, nxt_dp_udma, dp_ident_ff, nxt_dp_ident;
  logic dp_halt_ff, nxt_dp_halt, rb_valid_ff, nxt_rb_valid, ready_ff, nxt_ready;
  logic [7:0] rb_byte_ff, nxt_rb_byte;
  logic busy_ff, nxt_busy;
  logic [7:0] sig_reg_ff, nxt_sig_reg;
  logic lun_ff, nxt_lun, rejected_ff, nxt_rejected, halted_ff, nxt_halted;
  logic [31:0] rdata_ff, nxt_rdata;
  logic ram_we, scan_found, blk_ok, dev_bit, reject_set, halt_set, fault_stop;
  logic [2:0] scan_idx;
  logic [3:0] ram_raddr;
  logic [7:0] ram_rdata;
  logic [1:0] status_clr;
  ata_block_pkg::exec_state_e after_poll;

  block_store u_store (
    .mclk(mclk),
    .arst_n(arst_n),
    .we(ram_we),
    .waddr(cnt_ff),
    .wdata(blk_byte),
    .raddr(ram_raddr),
    .rdata(ram_rdata)
  );

  mask_scan u_scan (
    .mask(mask_ff),
    .start(idx_ff),
    .found(scan_found),
    .idx(scan_idx)
  );

  assign blk_ok = (sig_ff == sig_reg_ff) && (sub_ff == ata_block_pkg::subcmd_value);
  assign dev_bit = action_ff[ata_block_pkg::flag_dev_src] ? devhead_ff[ata_block_pkg::drive_sel_pos] : lun_ff;
  assign after_poll = (action_ff[ata_block_pkg::flag_readback] || action_ff[ata_block_pkg::flag_late_sel]) ?
                      ata_block_pkg::st_scan : ata_block_pkg::st_sel;
  assign fault_stop = (dp_dev_err && !action_ff[ata_block_pkg::flag_dev_cont]) ||
                      (dp_phase_err && !action_ff[ata_block_pkg::flag_phase_cont]);
  assign ram_raddr = ata_block_pkg::byte_wr_base + {1'b0, scan_idx};

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sig = sig_ff;
    nxt_sub = sub_ff;
    nxt_action = action_ff;
    nxt_mask = mask_ff;
    nxt_devhead = devhead_ff;
    nxt_idx = idx_ff;
    nxt_acc = acc_ff;
    nxt_rbcnt = rbcnt_ff;
    nxt_rb = rb_ff;
    nxt_tf_req = tf_req_ff;
    nxt_tf_write = tf_write_ff;
    nxt_tf_ctrl = tf_ctrl_ff;
    nxt_tf_addr = tf_addr_ff;
    nxt_tf_wdata = tf_wdata_ff;
    nxt_dp_start = 1'b0;
    nxt_dp_udma = dp_udma_ff;
    nxt_dp_ident = dp_ident_ff;
    nxt_dp_halt = 1'b0;
    nxt_rb_valid = 1'b0;
    nxt_rb_byte = 8'h00;
    ram_we = 1'b0;
    reject_set = 1'b0;
    halt_set = 1'b0;
    case (state_ff)
      ata_block_pkg::st_idle: begin
        if (blk_valid) begin
          ram_we = 1'b1;
          nxt_cnt = cnt_ff + 4'h1;
          if (cnt_ff == ata_block_pkg::byte_sig) nxt_sig = blk_byte;
          if (cnt_ff == ata_block_pkg::byte_sub) nxt_sub = blk_byte;
          if (cnt_ff == ata_block_pkg::byte_action) nxt_action = blk_byte;
          if (cnt_ff == ata_block_pkg::byte_mask) nxt_mask = blk_byte;
          if (cnt_ff == ata_block_pkg::byte_devhead) nxt_devhead = blk_byte;
          if (cnt_ff == ata_block_pkg::blk_last) nxt_state = ata_block_pkg::st_check;
        end
      end
      ata_block_pkg::st_check: begin
        if (blk_ok) begin
          nxt_idx = 4'h0;
          nxt_rb = 64'h0;
          nxt_state = action_ff[ata_block_pkg::flag_skip_poll] ? after_poll : ata_block_pkg::st_poll;
        end else begin
          reject_set = 1'b1;
          nxt_state = ata_block_pkg::st_idle;
        end
      end
      ata_block_pkg::st_poll: begin
        if (tf_ack) begin
          nxt_tf_req = 1'b0;
          if (!tf_rdata[ata_block_pkg::busy_pos]) nxt_state = after_poll;
        end else if (!tf_req_ff) begin
          nxt_tf_req = 1'b1;
          nxt_tf_write = 1'b0;
          nxt_tf_ctrl = 1'b1;
          nxt_tf_addr = ata_block_pkg::alt_status_addr;
        end
      end
      ata_block_pkg::st_sel: begin
        if (tf_ack) begin
          nxt_tf_req = 1'b0;
          if (action_ff[ata_block_pkg::flag_late_sel]) begin
            nxt_state = ata_block_pkg::st_data;
            nxt_dp_start = 1'b1;
            nxt_dp_udma = action_ff[ata_block_pkg::flag_udma];
            nxt_dp_ident = action_ff[ata_block_pkg::flag_identify];
          end else begin
            nxt_state = ata_block_pkg::st_scan;
          end
        end else if (!tf_req_ff) begin
          nxt_tf_req = 1'b1;
          nxt_tf_write = 1'b1;
          nxt_tf_ctrl = 1'b0;
          nxt_tf_addr = ata_block_pkg::devhead_addr;
          nxt_tf_wdata = {devhead_ff[7:5], dev_bit, devhead_ff[3:0]};
        end
      end
      ata_block_pkg::st_scan: begin
        if (scan_found) begin
          nxt_acc = scan_idx;
          nxt_state = ata_block_pkg::st_fetch;
        end else if (action_ff[ata_block_pkg::flag_readback]) begin
          nxt_rbcnt = 3'h0;
          nxt_state = ata_block_pkg::st_rbout;
        end else if (action_ff[ata_block_pkg::flag_late_sel]) begin
          nxt_state = ata_block_pkg::st_sel;
        end else begin
          nxt_state = ata_block_pkg::st_data;
          nxt_dp_start = 1'b1;
          nxt_dp_udma = action_ff[ata_block_pkg::flag_udma];
          nxt_dp_ident = action_ff[ata_block_pkg::flag_identify];
        end
      end
      ata_block_pkg::st_fetch: begin
        nxt_tf_req = 1'b1;
        nxt_tf_write = !action_ff[ata_block_pkg::flag_readback];
        nxt_tf_ctrl = (acc_ff == 3'h0);
        nxt_tf_addr = (acc_ff == 3'h0) ? ata_block_pkg::alt_status_addr : acc_ff;
        nxt_tf_wdata = (acc_ff == ata_block_pkg::devhead_bit) ?
                       {ram_rdata[7:5], dev_bit, ram_rdata[3:0]} : ram_rdata;
        nxt_state = ata_block_pkg::st_acc;
      end
      ata_block_pkg::st_acc: begin
        if (tf_ack) begin
          nxt_tf_req = 1'b0;
          if (action_ff[ata_block_pkg::flag_readback]) nxt_rb[{acc_ff, 3'b000} +: 8] = tf_rdata;
          nxt_idx = {1'b0, acc_ff} + 4'h1;
          nxt_state = ata_block_pkg::st_scan;
        end
      end
      ata_block_pkg::st_data: begin
        if (fault_stop) begin
          nxt_dp_halt = 1'b1;
          halt_set = 1'b1;
          nxt_dp_udma = 1'b0;
          nxt_dp_ident = 1'b0;
          nxt_state = ata_block_pkg::st_idle;
        end else if (dp_done) begin
          nxt_dp_udma = 1'b0;
          nxt_dp_ident = 1'b0;
          nxt_state = ata_block_pkg::st_idle;
        end
      end
      ata_block_pkg::st_rbout: begin
        nxt_rb_valid = 1'b1;
        nxt_rb_byte = rb_ff[{rbcnt_ff, 3'b000} +: 8];
        nxt_rbcnt = rbcnt_ff + 3'h1;
        if (rbcnt_ff == ata_block_pkg::rb_last) nxt_state = ata_block_pkg::st_idle;
      end
      default: begin
        nxt_state = ata_block_pkg::st_idle;
      end
    endcase
    nxt_ready = (nxt_state == ata_block_pkg::st_idle);
    nxt_busy = (nxt_state != ata_block_pkg::st_idle);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ata_block_pkg::st_idle;
      cnt_ff <= 4'h0;
      sig_ff <= 8'h00;
      sub_ff <= 8'h00;
      action_ff <= 8'h00;
      mask_ff <= 8'h00;
      devhead_ff <= 8'h00;
      idx_ff <= 4'h0;
      acc_ff <= 3'h0;
      rbcnt_ff <= 3'h0;
      rb_ff <= 64'h0;
      tf_req_ff <= 1'b0;
      tf_write_ff <= 1'b0;
      tf_ctrl_ff <= 1'b0;
      tf_addr_ff <= 3'h0;
      tf_wdata_ff <= 8'h00;
      dp_start_ff <= 1'b0;
      dp_udma_ff <= 1'b0;
      dp_ident_ff <= 1'b0;
      dp_halt_ff <= 1'b0;
      rb_valid_ff <= 1'b0;
      rb_byte_ff <= 8'h00;
      ready_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sig_ff <= nxt_sig;
      sub_ff <= nxt_sub;
      action_ff <= nxt_action;
      mask_ff <= nxt_mask;
      devhead_ff <= nxt_devhead;
      idx_ff <= nxt_idx;
      acc_ff <= nxt_acc;
      rbcnt_ff <= nxt_rbcnt;
      rb_ff <= nxt_rb;
      tf_req_ff <= nxt_tf_req;
      tf_write_ff <= nxt_tf_write;
      tf_ctrl_ff <= nxt_tf_ctrl;
      tf_addr_ff <= nxt_tf_addr;
      tf_wdata_ff <= nxt_tf_wdata;
      dp_start_ff <= nxt_dp_start;
      dp_udma_ff <= nxt_dp_udma;
      dp_ident_ff <= nxt_dp_ident;
      dp_halt_ff <= nxt_dp_halt;
      rb_valid_ff <= nxt_rb_valid;
      rb_byte_ff <= nxt_rb_byte;
      ready_ff <= nxt_ready;
      busy_ff <= nxt_busy;
    end
  end

  // Sticky flags: a new event beats a clear in the same cycle
  always_comb begin
    status_clr = (reg_wr && reg_addr == ata_block_pkg::off_status) ? reg_wdata[2:1] : 2'b00;
    nxt_sig_reg = sig_reg_ff;
    nxt_lun = lun_ff;
    if (reg_wr && reg_addr == ata_block_pkg::off_sig) nxt_sig_reg = reg_wdata[7:0];
    if (reg_wr && reg_addr == ata_block_pkg::off_ctrl) nxt_lun = reg_wdata[0];
    nxt_rejected = reject_set | (rejected_ff & ~status_clr[0]);
    nxt_halted = halt_set | (halted_ff & ~status_clr[1]);
    nxt_rdata = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        ata_block_pkg::off_sig: nxt_rdata = {24'h0, sig_reg_ff};
        ata_block_pkg::off_ctrl: nxt_rdata = {31'h0, lun_ff};
        ata_block_pkg::off_status: nxt_rdata = {16'h0, action_ff, 5'h0, halted_ff, rejected_ff, busy_ff};
        ata_block_pkg::off_rb_lo: nxt_rdata = rb_ff[31:0];
        ata_block_pkg::off_rb_hi: nxt_rdata = rb_ff[63:32];
        default: nxt_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sig_reg_ff <= ata_block_pkg::sig_reset;
      lun_ff <= ata_block_pkg::lun_reset;
      rejected_ff <= 1'b0;
      halted_ff <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      sig_reg_ff <= nxt_sig_reg;
      lun_ff <= nxt_lun;
      rejected_ff <= nxt_rejected;
      halted_ff <= nxt_halted;
      rdata_ff <= nxt_rdata;
    end
  end

  assign blk_ready = ready_ff;
  assign reg_rdata = rdata_ff;
  assign tf_req = tf_req_ff;
  assign tf_write = tf_write_ff;
  assign tf_ctrl_blk = tf_ctrl_ff;
  assign tf_addr = tf_addr_ff;
  assign tf_wdata = tf_wdata_ff;
  assign dp_start = dp_start_ff;
  assign dp_udma = dp_udma_ff;
  assign dp_identify = dp_ident_ff;
  assign dp_halt = dp_halt_ff;
  assign rb_valid = rb_valid_ff;
  assign rb_byte = rb_byte_ff;
  assign busy = busy_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  ident_flag_a: assert property (dp_start_ff |-> dp_ident_ff == action_ff[7])
    else $error("identify flag not passed to data phase");
  udma_flag_a: assert property (state_ff == ata_block_pkg::st_data |-> dp_udma_ff == action_ff[6])
    else $error("ultra dma level wrong");
  dev_src_a: assert property (state_ff == ata_block_pkg::st_sel && tf_req_ff |-> tf_wdata_ff[4] == dev_bit)
    else $error("drive select bit from wrong source");
  dev_halt_a: assert property (state_ff == ata_block_pkg::st_data && dp_dev_err && !action_ff[4]
    |=> dp_halt_ff && state_ff == ata_block_pkg::st_idle)
    else $error("drive error did not halt");
  phase_cont_a: assert property (state_ff == ata_block_pkg::st_data && dp_phase_err && action_ff[3] && !dp_dev_err
    |=> !dp_halt_ff)
    else $error("phase error halted despite continue flag");
  poll_retry_a: assert property (state_ff == ata_block_pkg::st_poll && tf_ack && tf_rdata[7]
    |=> state_ff == ata_block_pkg::st_poll ##1 tf_req_ff && tf_ctrl_ff && !tf_write_ff)
    else $error("busy poll not repeated");
  skip_poll_a: assert property (state_ff == ata_block_pkg::st_check && blk_ok && action_ff[2]
    |=> state_ff != ata_block_pkg::st_poll)
    else $error("polled although skip flag set");
  early_sel_a: assert property (state_ff == ata_block_pkg::st_sel && tf_ack && !action_ff[1]
    |=> state_ff == ata_block_pkg::st_scan)
    else $error("early select order broken");
  readback_only_a: assert property (busy_ff && action_ff[0] |-> !dp_start_ff && !(tf_req_ff && tf_write_ff))
    else $error("readback issued write or data phase");
  mask_only_a: assert property (state_ff == ata_block_pkg::st_acc && $rose(tf_req_ff) |-> mask_ff[acc_ff])
    else $error("unmasked register accessed");
  order_up_a: assert property (state_ff == ata_block_pkg::st_acc && tf_ack |=> idx_ff == {1'b0, $past(acc_ff)} + 4'h1)
    else $error("access order not ascending");
  reg_map_a: assert property (state_ff == ata_block_pkg::st_acc |-> tf_ctrl_ff == (acc_ff == 3'h0) &&
    tf_addr_ff == ((acc_ff == 3'h0) ? 3'h6 : acc_ff))
    else $error("register map wrong");
  rb_len_a: assert property ($rose(rb_valid_ff) |-> rb_valid_ff [*8] ##1 !rb_valid_ff)
    else $error("readback not eight bytes");
  rb_zero_a: assert property (state_ff == ata_block_pkg::st_rbout && !mask_ff[rbcnt_ff] |=> rb_byte_ff == 8'h00)
    else $error("unmasked readback byte not zero");
  sig_reject_a: assert property (state_ff == ata_block_pkg::st_check && sig_ff != sig_reg_ff
    |=> state_ff == ata_block_pkg::st_idle && rejected_ff)
    else $error("bad signature accepted");

  readback_c: cover property ($fell(rb_valid_ff));
  halt_c: cover property (dp_halt_ff);
  poll_retry_c: cover property (state_ff == ata_block_pkg::st_poll && tf_ack && tf_rdata[7]);
  late_sel_c: cover property (state_ff == ata_block_pkg::st_sel && tf_ack && action_ff[1]);
endmodule
`default_nettype wire

//--- verilog/block_store.sv
`default_nettype none
module block_store (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [3:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [16];
  logic [7:0] rdata_ff;

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= mem[raddr];
    end
  end

  assign rdata = rdata_ff;
endmodule
`default_nettype wire

//--- verilog/mask_scan.sv
`default_nettype none
module mask_scan (
  input wire logic [7:0] mask,
  input wire logic [3:0] start,
  output logic found,
  output logic [2:0] idx
);
  logic [7:0] elig;

  for (genvar i = 0; i < 8; i++) begin : g_elig
    assign elig[i] = mask[i] && (start <= 4'(i));
  end

  // Lowest eligible bit wins, so accesses climb upward
  always_comb begin
    found = |elig;
    idx = 3'h0;
    for (int j = 7; j >= 0; j--) begin
      if (elig[j]) begin
        idx = 3'(j);
      end
    end
  end
endmodule
`default_nettype wire
